// ### dv/afpm_ctrl_monitor.sv
`timescale 1ns/100ps
// ==========================================
// port checker for the frame and power mode control
module afpm_ctrl_monitor #(
   parameter int CODE_W = 12 // result width
) (
   input wire logic ref_clk, // core clock
   input wire logic srst, // sync reset
   input wire logic sclk, // link clock
   input wire logic frame_sel_n, // frame select
   input wire logic [CODE_W-1:0] sample_code, // core code
   input wire logic serial_result_out, // serial data
   input wire logic serial_result_oe_n, // pin enable
   input wire logic track_q, // track flag
   input afpm_pkg::afpm_mode_t mode_q, // power mode
   input wire logic analog_on_q, // analog power
   input wire logic bias_on_q, // bias power
   input wire logic result_valid_q // valid pulse
);
   logic [4:0] rise_cnt_q; // rising edges seen in this frame
   // ==========================================
   // helper: clears while frame is high, so idle sclk cannot fool it
   always_ff @(posedge sclk or posedge frame_sel_n) begin
      if (frame_sel_n) begin
         rise_cnt_q <= 5'h00;
      end else if (rise_cnt_q != 5'h1f) begin
         rise_cnt_q <= rise_cnt_q + 5'h01;
      end
   end
   // mode settled: frame high long past the classify delay
   sequence s_idle;
      frame_sel_n [*8];
   endsequence
   // ==========================================
   // core domain
   a_partial_power: assert property (@(posedge ref_clk) disable iff (srst)
      s_idle ##0 mode_q == afpm_pkg::AFPM_PARTIAL |-> !analog_on_q && bias_on_q)
      else $error("partial mode power wrong");
   a_full_power: assert property (@(posedge ref_clk) disable iff (srst)
      s_idle ##0 mode_q == afpm_pkg::AFPM_FULL |-> !analog_on_q && !bias_on_q)
      else $error("full mode power wrong");
   a_normal_power: assert property (@(posedge ref_clk) disable iff (srst)
      mode_q == afpm_pkg::AFPM_NORMAL |-> analog_on_q && bias_on_q)
      else $error("normal mode power wrong");
   a_valid_single: assert property (@(posedge ref_clk) disable iff (srst)
      result_valid_q |=> !result_valid_q)
      else $error("valid pulse too long");
   a_valid_cause: assert property (@(posedge ref_clk) disable iff (srst)
      result_valid_q |-> mode_q == afpm_pkg::AFPM_NORMAL && $past(frame_sel_n, 2))
      else $error("valid pulse without frame end");
   a_float_idle: assert property (@(posedge ref_clk) disable iff (srst)
      frame_sel_n [*2] |-> serial_result_oe_n)
      else $error("pin driven outside frame");
   // ==========================================
   // link domain, sampled at host capture edges
   a_lead_zeros: assert property (@(posedge sclk) disable iff (srst)
      !frame_sel_n && rise_cnt_q < 5'h04 |-> !serial_result_oe_n && !serial_result_out)
      else $error("leading zero bit wrong");
   a_track_hold: assert property (@(posedge sclk) disable iff (srst)
      !frame_sel_n && rise_cnt_q inside {[5'h01:5'h0c]} |-> !track_q)
      else $error("track early");
   a_track_back: assert property (@(posedge sclk) disable iff (srst)
      !frame_sel_n && rise_cnt_q inside {[5'h0d:5'h0f]} |-> track_q)
      else $error("track not resumed");
endmodule : afpm_ctrl_monitor

// ### dv/afpm_ctrl_test.sv
`timescale 1ns/100ps
// ==========================================
// self-checking bench
module afpm_ctrl_test;
   logic ref_clk = 1'b0; // core clock
   logic srst = 1'b1; // sync reset
   logic [11:0] sample_code = 12'h000; // core code
   logic sdo, oe_n, track_q, analog_on_q, bias_on_q, result_valid_q, sclk, frame_sel_n;
   afpm_pkg::afpm_mode_t mode_q; // power mode
   int valid_cnt = 0; // valid pulses seen so far
   int fail_count = 0;
   int check_count = 0;
   afpm_ctrl afpm_ctrl_i (.ref_clk(ref_clk), .srst(srst), .sclk(sclk),
      .frame_sel_n(frame_sel_n), .sample_code(sample_code), .serial_result_out(sdo),
      .serial_result_oe_n(oe_n), .track_q(track_q), .mode_q(mode_q),
      .analog_on_q(analog_on_q), .bias_on_q(bias_on_q), .result_valid_q(result_valid_q));
   afpm_host afpm_host_i (.sclk(sclk), .frame_sel_n(frame_sel_n), .serial_result_out(sdo),
      .serial_result_oe_n(oe_n));
   // 100 ns core clock
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // pulse lasts one cycle, so count it
   always @(posedge ref_clk) begin
      if (result_valid_q === 1'b1) valid_cnt <= valid_cnt + 1;
   end
   // ==========================================
   // shared tasks
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   // run a frame then judge the settled mode; gap covers classify delay
   task automatic frame_chk(input int n, input logic [11:0] code,
         input afpm_pkg::afpm_mode_t m, input logic v);
      int v0;
      @(posedge ref_clk);
      #1 sample_code = code;
      v0 = valid_cnt;
      #7 afpm_host_i.frame(n);
      repeat (12) @(posedge ref_clk);
      #1 cmp("mode", {14'h0, m}, {14'h0, mode_q});
      cmp("analog", {15'h0, m == afpm_pkg::AFPM_NORMAL}, {15'h0, analog_on_q});
      cmp("bias", {15'h0, m != afpm_pkg::AFPM_FULL}, {15'h0, bias_on_q});
      cmp("valid", {15'h0, v}, 16'(valid_cnt - v0));
      cmp("float", 16'h0001, {15'h0, oe_n});
      cmp("track", 16'h0001, {15'h0, track_q});
      if (v) cmp("word", {4'h0, code}, afpm_host_i.word);
   endtask : frame_chk
   task automatic end_of_test();
      if (fail_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   // ==========================================
   // scenarios
   task automatic s_read();
      frame_chk(16, 12'ha5c, afpm_pkg::AFPM_NORMAL, 1'b1);
      frame_chk(16, 12'hfff, afpm_pkg::AFPM_NORMAL, 1'b1);
   endtask : s_read
   task automatic s_short();
      frame_chk(1, 12'h123, afpm_pkg::AFPM_NORMAL, 1'b0);
      frame_chk(12, 12'h456, afpm_pkg::AFPM_NORMAL, 1'b0);
      frame_chk(15, 12'h789, afpm_pkg::AFPM_NORMAL, 1'b0);
   endtask : s_short
   task automatic s_power();
      frame_chk(9, 12'h111, afpm_pkg::AFPM_PARTIAL, 1'b0);
      frame_chk(10, 12'h222, afpm_pkg::AFPM_NORMAL, 1'b0);
      frame_chk(2, 12'h333, afpm_pkg::AFPM_PARTIAL, 1'b0);
      frame_chk(1, 12'h444, afpm_pkg::AFPM_PARTIAL, 1'b0);
      frame_chk(5, 12'h555, afpm_pkg::AFPM_FULL, 1'b0);
      frame_chk(9, 12'h666, afpm_pkg::AFPM_FULL, 1'b0);
      frame_chk(16, 12'h777, afpm_pkg::AFPM_NORMAL, 1'b0);
      frame_chk(16, 12'h0c3, afpm_pkg::AFPM_NORMAL, 1'b1);
   endtask : s_power
   // hang guard
   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge ref_clk);
      s_read();
      s_short();
      s_power();
      end_of_test();
   end
endmodule : afpm_ctrl_test
bind afpm_ctrl afpm_ctrl_monitor #(.CODE_W(CODE_W)) afpm_ctrl_monitor_i (.ref_clk(ref_clk),
   .srst(srst), .sclk(sclk), .frame_sel_n(frame_sel_n), .sample_code(sample_code),
   .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
   .track_q(track_q), .mode_q(mode_q), .analog_on_q(analog_on_q), .bias_on_q(bias_on_q),
   .result_valid_q(result_valid_q));

// ### dv/afpm_host.sv
`timescale 1ns/100ps
// ==========================================
// host serial controller: 48 ns sclk, only runs inside frames
module afpm_host (
   output logic sclk, // link clock, idles high
   output logic frame_sel_n, // frame select
   input wire logic serial_result_out, // serial data
   input wire logic serial_result_oe_n // pin enable
);
   logic [15:0] word; // bits captured on rising edges
   // idle high between frames
   initial begin
      sclk = 1'b1;
      frame_sel_n = 1'b1;
      word = 16'h0000;
   end
   // one frame of n falling edges; a floating pin reads as z
   task automatic frame(input int n);
      frame_sel_n = 1'b0;
      word = 16'h0000;
      #24;
      repeat (n) begin
         sclk = 1'b0;
         #24;
         sclk = 1'b1;
         word = {word[14:0], serial_result_oe_n ? 1'bz : serial_result_out};
         #24;
      end
      // hold the frame past one core cycle so short frames are seen
      #100;
      frame_sel_n = 1'b1;
   endtask : frame
endmodule : afpm_host

// ### rtl/afpm_ctrl.sv
`timescale 1ns/100ps
`include "afpm_map.svh"

// ==========================================
// frame select driven conversion and power mode control
module afpm_ctrl #(
   parameter int CODE_W = `AFPM_CODE_BITS, // result width
   parameter afpm_pkg::afpm_mode_t INIT_MODE = afpm_pkg::AFPM_NORMAL // mode after reset
) (
   input wire logic ref_clk, // core clock
   input wire logic srst, // sync reset, high
   input wire logic sclk, // serial clock from host
   input wire logic frame_sel_n, // frame select, low active
   input wire logic [CODE_W-1:0] sample_code, // code from converter core
   output logic serial_result_out, // serial data, pin output
   output logic serial_result_oe_n, // pin drive enable, low drives
   output logic track_q, // high while track-and-hold tracks
   output afpm_pkg::afpm_mode_t mode_q, // current power mode
   output logic analog_on_q, // analog circuits powered
   output logic bias_on_q, // bias generator powered
   output logic result_valid_q // pulse: valid word was read out
);

   // ==========================================
   // elaboration check
   generate
      if (CODE_W + `AFPM_LEAD_ZEROS != `AFPM_WORD_BITS) begin : g_bad_w
         $error("code width does not fit the serial word");
      end
   endgenerate

   localparam int CW = `AFPM_CNT_W;

   // ==========================================
   // gray helpers for the count crossing
   function automatic logic [CW-1:0] bin2gray(input logic [CW-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction : bin2gray

   function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
      logic [CW-1:0] b;
      b = '0;
      for (int i = CW - 1; i >= 0; i--) begin
         b[i] = (i == CW - 1) ? g[i] : (b[i+1] ^ g[i]);
      end
      gray2bin = b;
   endfunction : gray2bin

   // ==========================================
   // reset handed to the link domain
   logic link_rst_q; // registered reset, drives async clears
   logic link_rst_d;

   // next value of link reset
   always_comb begin
      link_rst_d = srst;
   end

   // register link reset
   always_ff @(posedge ref_clk) begin
      link_rst_q <= link_rst_d;
   end

   // ==========================================
   // link domain: frame start flag
   logic fresh_q; // high until first falling edge of frame
   logic fresh_d;

   // cleared by first falling edge of a frame
   always_comb begin
      fresh_d = 1'b0;
   end

   // set while frame select is high, so each frame restarts
   always_ff @(negedge sclk or posedge frame_sel_n or posedge link_rst_q) begin
      if (link_rst_q) begin
         fresh_q <= 1'b1;
      end else if (frame_sel_n) begin
         fresh_q <= 1'b1; // [R18]
      end else begin
         fresh_q <= fresh_d;
      end
   end

   // ==========================================
   // link domain: falling-edge counter
   logic [CW-1:0] cnt_q; // falling edges in this frame
   logic [CW-1:0] cnt_d;
   logic [CW-1:0] cnt_gray_q; // gray copy for the crossing
   logic [CW-1:0] cnt_gray_d;

   // restart at one on first edge, saturate past the word
   always_comb begin
      if (fresh_q) begin
         cnt_d = `AFPM_CNT_ONE; // [R18]
      end else if (cnt_q == `AFPM_CNT_SAT) begin
         cnt_d = cnt_q; // hold, no wrap
      end else begin
         cnt_d = cnt_q + `AFPM_CNT_ONE; // [R18]
      end
      cnt_gray_d = bin2gray(cnt_d);
   end

   // count held after the frame ends so the core can classify it
   always_ff @(negedge sclk or posedge link_rst_q) begin
      if (link_rst_q) begin
         cnt_q <= `AFPM_CNT_ZERO;
         cnt_gray_q <= `AFPM_CNT_ZERO;
      end else if (!frame_sel_n) begin
         cnt_q <= cnt_d;
         cnt_gray_q <= cnt_gray_d;
      end
   end

   // ==========================================
   // link domain: code capture
   // multi-bit pass is safe only because the core holds the code
   // steady from the frame fall until the end of conversion; a flop
   // chain here would hand over a stale code, as sclk stops between frames
   logic [`AFPM_WORD_BITS-1:0] word_q; // word being shifted out
   logic [`AFPM_WORD_BITS-1:0] word_d;

   // load the word on the first edge of the frame
   always_comb begin
      if (fresh_q) begin
         word_d = {`AFPM_LEAD_VAL, sample_code}; // [R1] [R14]
      end else begin
         word_d = word_q;
      end
   end

   // register the word, only inside a frame
   always_ff @(negedge sclk or posedge link_rst_q) begin
      if (link_rst_q) begin
         word_q <= '0;
      end else if (!frame_sel_n) begin
         word_q <= word_d;
      end
   end

   // ==========================================
   // link domain: serial output pin
   logic sdo_q; // data bit on the pin
   logic sdo_d;
   logic oe_n_q; // pin enable, low drives
   logic oe_n_d;
   logic [CW-1:0] bit_idx; // word bit for this edge

   // edge n shows word bit 16-n, msb first
   always_comb begin
      bit_idx = CW'(`AFPM_EDGE_WORD - cnt_d);
      if (cnt_d <= `AFPM_EDGE_WORD) begin
         sdo_d = word_d[bit_idx[3:0]]; // [R14]
      end else begin
         sdo_d = 1'b0;
      end
      // float after the last bit of the word
      oe_n_d = (cnt_d > `AFPM_EDGE_DONE); // [R5]
   end

   // a rise of frame select floats the pin at once
   always_ff @(negedge sclk or posedge frame_sel_n or posedge link_rst_q) begin
      if (link_rst_q) begin
         sdo_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (frame_sel_n) begin
         sdo_q <= 1'b0;
         oe_n_q <= 1'b1; // [R4] [R8]
      end else begin
         sdo_q <= sdo_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign serial_result_out = sdo_q;
   assign serial_result_oe_n = oe_n_q;

   // ==========================================
   // link domain: track-and-hold control
   logic trk_q; // track state
   logic trk_d;

   // hold from the first rise of the frame, track again at the 13th rise
   always_comb begin
      trk_d = !fresh_q && (cnt_q >= `AFPM_TRACK_FALLS); // [R15]
   end

   // tracks while idle; rising edges only
   always_ff @(posedge sclk or posedge frame_sel_n or posedge link_rst_q) begin
      if (link_rst_q) begin
         trk_q <= 1'b1;
      end else if (frame_sel_n) begin
         trk_q <= 1'b1;
      end else begin
         trk_q <= trk_d;
      end
   end

   assign track_q = trk_q;

   // ==========================================
   // core domain: synchronisers
   logic fs_meta_q; // first stage, read by fs_sync_q only
   logic fs_sync_q;
   logic fs_prev_q; // last synced level
   logic [CW-1:0] g_meta_q; // first stage of count
   logic [CW-1:0] g_sync_q;
   logic fs_meta_d;
   logic fs_sync_d;
   logic fs_prev_d;
   logic [CW-1:0] g_meta_d;
   logic [CW-1:0] g_sync_d;

   // next values of the synchroniser chain
   always_comb begin
      fs_meta_d = frame_sel_n;
      fs_sync_d = fs_meta_q;
      fs_prev_d = fs_sync_q;
      g_meta_d = cnt_gray_q;
      g_sync_d = g_meta_q;
   end

   // one flop pair per count bit
   generate
      for (genvar gi = 0; gi < CW; gi++) begin : g_cnt_sync
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               g_meta_q[gi] <= 1'b0;
               g_sync_q[gi] <= 1'b0;
            end else begin
               g_meta_q[gi] <= g_meta_d[gi];
               g_sync_q[gi] <= g_sync_d[gi];
            end
         end
      end
   endgenerate

   // frame select chain idles high
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fs_meta_q <= 1'b1;
         fs_sync_q <= 1'b1;
         fs_prev_q <= 1'b1;
      end else begin
         fs_meta_q <= fs_meta_d;
         fs_sync_q <= fs_sync_d;
         fs_prev_q <= fs_prev_d;
      end
   end

   // ==========================================
   // core domain: mode machine
   // the count is read one cycle after the rise is seen, since it
   // may have crossed one cycle later than frame select
   logic fall_seen; // frame started
   logic rise_seen; // frame ended
   logic pend_q; // classify next cycle
   logic pend_d;
   logic frm_norm_q; // frame began in normal mode
   logic frm_norm_d;
   logic [CW-1:0] edges; // falling edges of the ended frame
   afpm_pkg::afpm_mode_t mode_d;
   logic analog_on_d;
   logic bias_on_d;
   logic valid_d;

   // next mode from the edge count at frame end
   always_comb begin
      fall_seen = fs_prev_q && !fs_sync_q;
      rise_seen = !fs_prev_q && fs_sync_q;
      edges = gray2bin(g_sync_q);
      pend_d = rise_seen;
      frm_norm_d = frm_norm_q;
      mode_d = mode_q;
      analog_on_d = analog_on_q;
      bias_on_d = bias_on_q;
      valid_d = 1'b0;
      if (fall_seen) begin
         // sample taken, power up begins on any frame fall
         frm_norm_d = (mode_q == afpm_pkg::AFPM_NORMAL); // [R1]
         analog_on_d = 1'b1; // [R10]
         bias_on_d = 1'b1;
      end else if (pend_q) begin
         if (edges >= `AFPM_EDGE_KEEP) begin
            // long frame: powered, dummy or aborted alike
            mode_d = afpm_pkg::AFPM_NORMAL; // [R4] [R10]
         end else if (edges >= `AFPM_EDGE_GLITCH) begin
            case (mode_q)
               afpm_pkg::AFPM_NORMAL: mode_d = afpm_pkg::AFPM_PARTIAL; // [R8]
               afpm_pkg::AFPM_PARTIAL: mode_d = afpm_pkg::AFPM_FULL; // [R13]
               afpm_pkg::AFPM_FULL: mode_d = afpm_pkg::AFPM_FULL;
               default: mode_d = afpm_pkg::AFPM_NORMAL;
            endcase
         end else begin
            // glitch: back to where the frame began
            mode_d = mode_q; // [R9] [R12]
         end
         analog_on_d = (mode_d == afpm_pkg::AFPM_NORMAL); // [R2]
         bias_on_d = (mode_d != afpm_pkg::AFPM_FULL);
         // a dummy frame never yields a valid word
         valid_d = frm_norm_q && (edges >= `AFPM_EDGE_DONE); // [R5] [R11]
      end
   end

   // register mode state; start mode is a parameter
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pend_q <= 1'b0;
         frm_norm_q <= 1'b0;
         mode_q <= INIT_MODE; // [R17]
         analog_on_q <= (INIT_MODE == afpm_pkg::AFPM_NORMAL);
         bias_on_q <= (INIT_MODE != afpm_pkg::AFPM_FULL);
         result_valid_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         frm_norm_q <= frm_norm_d;
         mode_q <= mode_d;
         analog_on_q <= analog_on_d;
         bias_on_q <= bias_on_d;
         result_valid_q <= valid_d;
      end
   end

endmodule : afpm_ctrl

// ### rtl/afpm_map.svh
`ifndef AFPM_MAP_SVH
`define AFPM_MAP_SVH
// Overview of operation
// R1: sample and start conversion at frame fall
// R2: three modes chosen by frame rise edge count
// R3: host holds frame low ten edges
// R4: rise in 10..15 aborts, stays powered, floats
// R5: sixteen clocks convert and read one result
// R6: frame may idle high or low
// R7: host waits frame gap after float
// R8: normal, rise in 2..9 enters partial
// R9: normal, rise before 2 stays normal
// R10: dummy frame past ten edges powers up
// R11: powered after 16, next frame valid
// R12: partial, rise before 2 stays partial
// R13: partial, rise in 2..9 enters full
// R14: word is four zeros then code msb-first
// R15: track resumes at 13th rising edge
// R16: host waits power-up time after full
// R17: start mode arbitrary, host issues dummies
// R18: count falling edges, clear each frame

// ==========================================
// conversion word layout
`define AFPM_CODE_BITS 12
`define AFPM_LEAD_ZEROS 4
`define AFPM_WORD_BITS 16
`define AFPM_LEAD_VAL 4'h0

// ==========================================
// falling-edge counter and thresholds
`define AFPM_CNT_W 5
`define AFPM_CNT_ZERO 5'h00
`define AFPM_CNT_ONE 5'h01
`define AFPM_CNT_SAT 5'h11
`define AFPM_EDGE_GLITCH 5'h02
`define AFPM_EDGE_KEEP 5'h0a
`define AFPM_EDGE_DONE 5'h10
`define AFPM_EDGE_WORD 5'h10
`define AFPM_TRACK_FALLS 5'h0d
`endif

// ### rtl/afpm_pkg.sv
// ==========================================
// shared types
package afpm_pkg;
   // power mode of the converter
   typedef enum logic [1:0] {
      AFPM_NORMAL,
      AFPM_PARTIAL,
      AFPM_FULL
   } afpm_mode_t;
endpackage : afpm_pkg
